// ==== logic/fpu_exception_rounding_ctrl.sv ====
// FPU exception detection, default results and rounding control
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Status holds cause 17..12, enable 11..7, flag 6..2; all RW, reset zero.
// - Field order high to low: error, invalid, div-zero, overflow, underflow, inexact.
// - Flag bits stay one once set until software writes them zero.
// - Rounding field 1..0: 00 nearest, 01 toward zero, reset 01.
// - A 32-bit transfer register is loaded and stored by the core.
// - Rounding happens once when the final result is formed.
// - Nearest rounding picks nearest value, ties go to even LSB.
// - Nearest rounding at or past the top threshold gives signed infinity.
// - Toward-zero drops low bits and saturates to signed maximum magnitude.
// - Issue with unit off raises disable exception, slot or general variant.
// - Detect error, invalid, zero divisor, overflow, underflow and inexact.
// - The error source cannot be masked and always traps.
// - Occurring sources set cause and, except error, flag; others clear cause, keep flag.
// - Invalid traps on invalid or transform; divide traps on zero divisor only.
// - Overflow, underflow, inexact trap on any instruction that could raise them.
// - All sources share one exception event toward the core.
// - A trapped instruction leaves its destination register unchanged.
// - Untrapped invalid writes a quiet NaN.
// - Untrapped divide by zero writes signed infinity.
// - Untrapped overflow writes signed max (toward zero) or signed infinity (nearest).
// - Untrapped underflow writes denormal or zero; flush gives zero; inexact as computed.
// - Denormal flush bit 18 resets to one; one treats denormals as zero.
module fpu_exception_rounding_ctrl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // System register load/store from the core
  input wire logic sr_wr_i,
  input wire logic sr_sel_i,
  input wire logic [31:0] sr_wdata_i,
  output logic [31:0] sr_rdata_o,
  // Transfer register load from the FPU side
  input wire logic xfer_we_i,
  input wire logic [31:0] xfer_wdata_i,
  // Operation issue
  input wire logic unit_off_bit_i,
  input wire logic op_valid_i,
  input wire fpu_exc_pkg::op_req_t op_i,
  // Answer and control state
  output fpu_exc_pkg::op_rsp_t rsp_o,
  output logic [1:0] round_mode_o,
  output logic denormal_flush_o
);

  // ==========================================
  // Conservative hazard classes per operation
  function automatic logic may_round(input fpu_exc_pkg::op_kind_t k);
    case (k)
      fpu_exc_pkg::OP_ADD, fpu_exc_pkg::OP_SUB, fpu_exc_pkg::OP_MUL,
      fpu_exc_pkg::OP_DIV, fpu_exc_pkg::OP_FUSED_MULTIPLY_ACCUMULATE, fpu_exc_pkg::OP_VECTOR_INNER_PRODUCT,
      fpu_exc_pkg::OP_MATRIX_VECTOR_TRANSFORM, fpu_exc_pkg::OP_RSQRT: may_round = 1'b1;
      default: may_round = 1'b0;
    endcase
  endfunction

  // ==========================================
  // State
  logic [5:0] cause_r, cause_nxt;
  logic [4:0] en_r, en_nxt;
  logic [4:0] flag_r, flag_nxt;
  logic [1:0] rnd_r, rnd_nxt;
  logic dnf_r, dnf_nxt;
  logic [31:0] xfer_r, xfer_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  fpu_exc_pkg::op_rsp_t rsp_r, rsp_nxt;

  // Rounding and exception working values
  logic inc;
  logic [24:0] msum;
  logic [23:0] mrnd;
  logic signed [9:0] erounded;
  logic ovf, unf, inx, err, inv, dz;
  logic [23:0] dmant;
  logic [9:0] shamt;
  logic [31:0] norm_res, def_res;
  logic [5:0] src;
  logic [4:0] trap_cond;
  logic trap;
  logic [31:0] status_view;

  // ==========================================
  // Rounding of the unrounded significand, done exactly once
  always_comb begin
    // Nearest: round up on guard when sticky or odd LSB (ties to even)
    if (rnd_r == fpu_exc_pkg::RND_NEAREST) begin
      inc = op_i.guard & (op_i.sticky | op_i.mant[0]);
    end else begin
      inc = 1'b0;
    end
    msum = {1'b0, op_i.mant} + {24'h000000, inc};
    if (msum[24]) begin
      mrnd = msum[24:1];
      erounded = op_i.exp + 10'sd1;
    end else begin
      mrnd = msum[23:0];
      erounded = op_i.exp;
    end
    // Past the largest exponent after rounding is the overflow threshold
    ovf = erounded >= $signed(fpu_exc_pkg::EXP_OVF);
    unf = erounded <= 10'sd0;
    inx = op_i.guard | op_i.sticky | ovf | unf;
    // Denormal result is truncated by the shift; loses accuracy, not sign
    shamt = 10'(10'sd1 - op_i.exp);
    dmant = (shamt > 10'd23) ? 24'h000000 : (op_i.mant >> shamt[4:0]);
    norm_res = {op_i.sign, erounded[7:0], mrnd[22:0]};
  end

  // ==========================================
  // Source detection and trap decision
  always_comb begin
    err = op_i.denorm_in & ~dnf_r;
    inv = op_i.nan_in;
    dz = op_i.zero_div;
    src = 6'h00;
    if (may_round(op_i.kind)) begin
      src = {err, inv, dz, ovf, unf, inx};
    end else begin
      src = {err, inv, 4'h0};
    end
    // Transform and inner product always report inexact
    if (op_i.kind == fpu_exc_pkg::OP_MATRIX_VECTOR_TRANSFORM || op_i.kind == fpu_exc_pkg::OP_VECTOR_INNER_PRODUCT) begin
      src[fpu_exc_pkg::X_I] = 1'b1;
    end
    trap_cond = 5'h00;
    trap_cond[fpu_exc_pkg::X_V] = inv | (op_i.kind == fpu_exc_pkg::OP_MATRIX_VECTOR_TRANSFORM);
    trap_cond[fpu_exc_pkg::X_Z] = dz;
    // Judged from the instruction, not the result, so software sees early traps
    trap_cond[fpu_exc_pkg::X_O] = may_round(op_i.kind);
    trap_cond[fpu_exc_pkg::X_U] = may_round(op_i.kind);
    trap_cond[fpu_exc_pkg::X_I] = may_round(op_i.kind);
    trap = err | (|(en_r & trap_cond));
  end

  // ==========================================
  // Default results for untrapped sources, priority invalid first
  always_comb begin
    if (inv) begin
      def_res = fpu_exc_pkg::QNAN;
    end else if (dz) begin
      def_res = {op_i.sign, fpu_exc_pkg::MAG_INF};
    end else if (ovf && rnd_r == fpu_exc_pkg::RND_ZERO) begin
      def_res = {op_i.sign, fpu_exc_pkg::MAG_MAX};
    end else if (ovf) begin
      def_res = {op_i.sign, fpu_exc_pkg::MAG_INF};
    end else if (unf && dnf_r) begin
      def_res = {op_i.sign, 31'h00000000};
    end else if (unf) begin
      def_res = {op_i.sign, 8'h00, dmant[22:0]};
    end else begin
      def_res = norm_res;
    end
  end

  // ==========================================
  // Next state of registers and answer
  always_comb begin
    cause_nxt = cause_r;
    en_nxt = en_r;
    flag_nxt = flag_r;
    rnd_nxt = rnd_r;
    dnf_nxt = dnf_r;
    xfer_nxt = xfer_r;
    rsp_nxt = '0;
    // Software write lands first; a same-cycle operation still used old fields
    if (sr_wr_i && sr_sel_i == fpu_exc_pkg::SEL_STATUS) begin
      cause_nxt = sr_wdata_i[fpu_exc_pkg::CAUSE_HI:fpu_exc_pkg::CAUSE_LO];
      en_nxt = sr_wdata_i[fpu_exc_pkg::EN_HI:fpu_exc_pkg::EN_LO];
      flag_nxt = sr_wdata_i[fpu_exc_pkg::FLAG_HI:fpu_exc_pkg::FLAG_LO];
      rnd_nxt = sr_wdata_i[fpu_exc_pkg::RND_HI:fpu_exc_pkg::RND_LO];
      dnf_nxt = sr_wdata_i[fpu_exc_pkg::DNF_BIT];
    end
    if (sr_wr_i && sr_sel_i == fpu_exc_pkg::SEL_XFER) begin
      xfer_nxt = sr_wdata_i;
    end else if (xfer_we_i) begin
      xfer_nxt = xfer_wdata_i;
    end
    if (op_valid_i) begin
      rsp_nxt.done = 1'b1;
      if (unit_off_bit_i) begin
        rsp_nxt.dis_slot = op_i.slot;
        rsp_nxt.dis_gen = ~op_i.slot;
      end else begin
        // Cause follows the operation; flag only accumulates, so set beats a clear
        cause_nxt = src;
        flag_nxt = flag_nxt | src[4:0];
        rsp_nxt.fpu_exc = trap;
        rsp_nxt.result_we = ~trap & (op_i.kind != fpu_exc_pkg::OP_CMP);
        rsp_nxt.result = trap ? 32'h00000000 : def_res;
      end
    end
  end

  // ==========================================
  // Store path view of the selected register, one cycle behind
  always_comb begin
    status_view = 32'h00000000;
    status_view[fpu_exc_pkg::DNF_BIT] = dnf_r;
    status_view[fpu_exc_pkg::CAUSE_HI:fpu_exc_pkg::CAUSE_LO] = cause_r;
    status_view[fpu_exc_pkg::EN_HI:fpu_exc_pkg::EN_LO] = en_r;
    status_view[fpu_exc_pkg::FLAG_HI:fpu_exc_pkg::FLAG_LO] = flag_r;
    status_view[fpu_exc_pkg::RND_HI:fpu_exc_pkg::RND_LO] = rnd_r;
    rdata_nxt = (sr_sel_i == fpu_exc_pkg::SEL_XFER) ? xfer_r : status_view;
  end

  // ==========================================
  // Registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cause_r <= 6'h00;
      en_r <= 5'h00;
      flag_r <= 5'h00;
      rnd_r <= fpu_exc_pkg::RND_RST;
      dnf_r <= fpu_exc_pkg::DNF_RST;
      xfer_r <= 32'h00000000;
      rdata_r <= 32'h00000000;
      rsp_r <= '0;
    end else begin
      cause_r <= cause_nxt;
      en_r <= en_nxt;
      flag_r <= flag_nxt;
      rnd_r <= rnd_nxt;
      dnf_r <= dnf_nxt;
      xfer_r <= xfer_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // Outputs straight from flops
  assign sr_rdata_o = rdata_r;
  assign rsp_o = rsp_r;
  assign round_mode_o = rnd_r;
  assign denormal_flush_o = dnf_r;

endmodule
`default_nettype wire

// ==== shared/fpu_exc_pkg.sv ====
// Package: field layout, reset values and carrier types of the FPU exception unit
package fpu_exc_pkg;
  // ==========================================
  // Status/control field positions
  localparam int CAUSE_HI = 17;
  localparam int CAUSE_LO = 12;
  localparam int EN_HI = 11;
  localparam int EN_LO = 7;
  localparam int FLAG_HI = 6;
  localparam int FLAG_LO = 2;
  localparam int DNF_BIT = 18;
  localparam int RND_HI = 1;
  localparam int RND_LO = 0;
  // Index within the five-bit enable/flag order: V Z O U I
  localparam int X_V = 4;
  localparam int X_Z = 3;
  localparam int X_O = 2;
  localparam int X_U = 1;
  localparam int X_I = 0;
  // ==========================================
  // Reset values and rounding-mode encodings
  localparam logic [1:0] RND_RST = 2'h1;
  localparam logic DNF_RST = 1'b1;
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_ZERO = 2'h1;
  // ==========================================
  // Single-precision result constants
  localparam logic [7:0] EXP_INF = 8'hFF;
  localparam logic [9:0] EXP_OVF = 10'h0FF;
  localparam logic [30:0] MAG_MAX = 31'h7F7FFFFF;
  localparam logic [30:0] MAG_INF = 31'h7F800000;
  localparam logic [31:0] QNAN = 32'h7FC00000;
  // System register selection
  localparam logic SEL_STATUS = 1'b0;
  localparam logic SEL_XFER = 1'b1;
  // ==========================================
  // Operation kinds
  typedef enum logic [3:0] {
    OP_MOVE, OP_CMP, OP_ADD, OP_SUB, OP_MUL, OP_DIV,
    OP_FUSED_MULTIPLY_ACCUMULATE, OP_VECTOR_INNER_PRODUCT, OP_MATRIX_VECTOR_TRANSFORM, OP_RSQRT, OP_FLOAT
  } op_kind_t;
  // Issued operation with its unrounded result
  typedef struct packed {
    op_kind_t kind;
    logic slot;
    logic denorm_in;
    logic nan_in;
    logic zero_div;
    logic sign;
    logic signed [9:0] exp;
    logic [23:0] mant;
    logic guard;
    logic sticky;
  } op_req_t;
  // Answer toward the core
  typedef struct packed {
    logic done;
    logic result_we;
    logic [31:0] result;
    logic fpu_exc;
    logic dis_gen;
    logic dis_slot;
  } op_rsp_t;
endpackage

// ==== testbench/fpu_exc_monitor.sv ====
// Checker: port-level timing relations of the FPU exception unit
`timescale 1ns/100ps
`default_nettype none
module fpu_exc_monitor (
  // Clock, reset and register bus
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sr_wr_i,
  input wire logic sr_sel_i,
  input wire logic [31:0] sr_wdata_i,
  input wire logic [31:0] sr_rdata_o,
  input wire logic xfer_we_i,
  // Operation side
  input wire logic unit_off_bit_i,
  input wire logic op_valid_i,
  input wire fpu_exc_pkg::op_req_t op_i,
  input wire fpu_exc_pkg::op_rsp_t rsp_o,
  input wire logic [1:0] round_mode_o,
  input wire logic denormal_flush_o
);
  // ==========================================
  // One clock domain; reset masks every check
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_fields: assert property ($rose(rst_n_i) |-> round_mode_o == 2'h1 && denormal_flush_o)
    else $error("rounding or flush field wrong after reset");
  a_done_next: assert property (op_valid_i && !unit_off_bit_i |=> rsp_o.done)
    else $error("no answer one cycle after issue");
  a_idle_quiet: assert property (!op_valid_i |=> !rsp_o.done && !rsp_o.fpu_exc)
    else $error("answer without issue");
  a_disable_kind: assert property (op_valid_i && unit_off_bit_i |=> rsp_o.dis_slot == $past(op_i.slot)
    && rsp_o.dis_gen != $past(op_i.slot) && !rsp_o.result_we)
    else $error("disable variant wrong");
  a_trap_hold: assert property (rsp_o.fpu_exc |-> rsp_o.done && !rsp_o.result_we)
    else $error("trapped result written");
  a_error_trap: assert property (op_valid_i && !unit_off_bit_i && op_i.denorm_in
    && !denormal_flush_o |=> rsp_o.fpu_exc)
    else $error("denormal input did not trap");
  a_mode_write: assert property (sr_wr_i && !sr_sel_i |=> round_mode_o == $past(sr_wdata_i[1:0]))
    else $error("rounding field not loaded");
  a_xfer_load: assert property (sr_wr_i && sr_sel_i ##1 sr_sel_i && !sr_wr_i && !xfer_we_i
    |=> sr_rdata_o == $past(sr_wdata_i, 2))
    else $error("transfer register read back wrong");
endmodule
bind fpu_exception_rounding_ctrl fpu_exc_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .sr_wr_i(sr_wr_i), .sr_sel_i(sr_sel_i), .sr_wdata_i(sr_wdata_i), .sr_rdata_o(sr_rdata_o),
  .xfer_we_i(xfer_we_i), .unit_off_bit_i(unit_off_bit_i), .op_valid_i(op_valid_i), .op_i(op_i),
  .rsp_o(rsp_o), .round_mode_o(round_mode_o), .denormal_flush_o(denormal_flush_o));
`default_nettype wire

// ==== testbench/core_model.sv ====
// Core model: issues floating-point operations and collects the answer
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // Clock and answer
  input wire logic ref_clk_i,
  input wire fpu_exc_pkg::op_rsp_t rsp_i,
  // Issue side
  output var logic op_valid_o,
  output var fpu_exc_pkg::op_req_t op_o,
  output var logic unit_off_o
);
  // Idle at time zero
  initial begin
    op_valid_o = 1'b0;
    op_o = '0;
    unit_off_o = 1'b0;
  end
  // One-cycle pulse; operands inverted after release so stale values never pass
  // The answer stands for one cycle only, so it is taken before the release
  task automatic issue(input fpu_exc_pkg::op_req_t req, input logic off,
      output fpu_exc_pkg::op_rsp_t got);
    @(negedge ref_clk_i);
    op_valid_o = 1'b1;
    op_o = req;
    unit_off_o = off;
    @(negedge ref_clk_i);
    got = rsp_i;
    op_valid_o = 1'b0;
    op_o = fpu_exc_pkg::op_req_t'(~req);
    @(negedge ref_clk_i);
    unit_off_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_fpu_exception_rounding_ctrl.sv ====
// Testbench: directed scenarios for the FPU exception unit
`timescale 1ns/100ps
`default_nettype none
module test_fpu_exception_rounding_ctrl;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sr_wr_i = 1'b0;
  logic sr_sel_i = 1'b0;
  logic [31:0] sr_wdata_i = 32'h0;
  logic xfer_we_i = 1'b0;
  logic [31:0] xfer_wdata_i = 32'h0;
  logic [31:0] sr_rdata_o;
  logic [31:0] rd;
  logic op_valid_i;
  logic unit_off_bit_i;
  fpu_exc_pkg::op_req_t op_i;
  fpu_exc_pkg::op_rsp_t rsp_o;
  fpu_exc_pkg::op_rsp_t r;
  logic [1:0] round_mode_o;
  logic denormal_flush_o;
  int n_mismatch = 0;
  int comparisons = 0;
  // ==========================================
  // 100 ns clock
  always #50 ref_clk_i = ~ref_clk_i;
  fpu_exception_rounding_ctrl uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sr_wr_i(sr_wr_i),
    .sr_sel_i(sr_sel_i), .sr_wdata_i(sr_wdata_i), .sr_rdata_o(sr_rdata_o), .xfer_we_i(xfer_we_i),
    .xfer_wdata_i(xfer_wdata_i), .unit_off_bit_i(unit_off_bit_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .rsp_o(rsp_o), .round_mode_o(round_mode_o), .denormal_flush_o(denormal_flush_o));
  core_model core (.ref_clk_i(ref_clk_i), .rsp_i(rsp_o), .op_valid_o(op_valid_i), .op_o(op_i),
    .unit_off_o(unit_off_bit_i));
  // ==========================================
  // Shared helpers
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic s, input logic [31:0] d);
    @(negedge ref_clk_i);
    sr_wr_i = 1'b1;
    sr_sel_i = s;
    sr_wdata_i = d;
    @(negedge ref_clk_i);
    sr_wr_i = 1'b0;
  endtask
  // Read data lags the select by one edge
  task automatic rdr(input logic s);
    @(negedge ref_clk_i);
    sr_sel_i = s;
    @(negedge ref_clk_i);
    rd = sr_rdata_o;
  endtask
  // Flags f = {slot, denorm, nan, zero divisor}
  function automatic fpu_exc_pkg::op_req_t mk(input fpu_exc_pkg::op_kind_t k, input logic [3:0] f,
      input logic s, input logic [9:0] e, input logic [23:0] m, input logic g);
    mk = '{k, f[3], f[2], f[1], f[0], s, e, m, g, 1'b0};
  endfunction
  task automatic op(input fpu_exc_pkg::op_req_t q, input logic off);
    core.issue(q, off, r);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset_xfer();
    rdr(1'b0);
    chk("status", 32'h00040001, rd);
    wr(1'b1, 32'hA5C30F96);
    rdr(1'b1);
    chk("xfer", 32'hA5C30F96, rd);
    @(negedge ref_clk_i);
    xfer_we_i = 1'b1;
    xfer_wdata_i = 32'h12345678;
    @(negedge ref_clk_i);
    xfer_we_i = 1'b0;
    rdr(1'b1);
    chk("xfer_fpu", 32'h12345678, rd);
  endtask
  task automatic t_invalid_sticky();
    wr(1'b0, 32'h00040000);
    op(mk(fpu_exc_pkg::OP_ADD, 4'h2, 1'b0, 10'h07F, 24'h800000, 1'b0), 1'b0);
    chk("qnan", fpu_exc_pkg::QNAN, r.result);
    rdr(1'b0);
    chk("status_v", 32'h00050040, rd);
    op(mk(fpu_exc_pkg::OP_ADD, 4'h0, 1'b0, 10'h07F, 24'h800000, 1'b0), 1'b0);
    rdr(1'b0);
    chk("flag_kept", 32'h00040040, rd);
    wr(1'b0, 32'h00040000);
    rdr(1'b0);
    chk("flag_clr", 32'h00040000, rd);
  endtask
  task automatic t_overflow();
    op(mk(fpu_exc_pkg::OP_ADD, 4'h0, 1'b1, 10'h0FF, 24'h800000, 1'b0), 1'b0);
    chk("ovf_near", 32'hFF800000, r.result);
    rdr(1'b0);
    chk("status_oi", 32'h00045014, rd);
    wr(1'b0, 32'h00040001);
    op(mk(fpu_exc_pkg::OP_ADD, 4'h0, 1'b1, 10'h0FF, 24'h800000, 1'b0), 1'b0);
    chk("ovf_zero", 32'hFF7FFFFF, r.result);
  endtask
  task automatic t_round_div();
    op(mk(fpu_exc_pkg::OP_MUL, 4'h0, 1'b0, 10'h07F, 24'h800001, 1'b1), 1'b0);
    chk("trunc", 32'h3F800001, r.result);
    wr(1'b0, 32'h00040000);
    op(mk(fpu_exc_pkg::OP_FUSED_MULTIPLY_ACCUMULATE, 4'h0, 1'b0, 10'h07F, 24'h800001, 1'b1), 1'b0);
    chk("tie_up", 32'h3F800002, r.result);
    op(mk(fpu_exc_pkg::OP_MUL, 4'h0, 1'b0, 10'h07F, 24'h800000, 1'b1), 1'b0);
    chk("tie_even", 32'h3F800000, r.result);
    op(mk(fpu_exc_pkg::OP_DIV, 4'h1, 1'b0, 10'h07F, 24'h800000, 1'b0), 1'b0);
    chk("div_inf", 32'h7F800000, r.result);
  endtask
  task automatic t_trap();
    wr(1'b0, 32'h00040800);
    op(mk(fpu_exc_pkg::OP_ADD, 4'h2, 1'b0, 10'h07F, 24'h800000, 1'b0), 1'b0);
    chk("trap_v", 32'h1, r.fpu_exc);
    chk("trap_we", 32'h0, r.result_we);
    wr(1'b0, 32'h00000000);
    op(mk(fpu_exc_pkg::OP_ADD, 4'h4, 1'b0, 10'h07F, 24'h800000, 1'b0), 1'b0);
    chk("trap_e", 32'h1, r.fpu_exc);
  endtask
  task automatic t_unit_off();
    wr(1'b0, 32'h00040000);
    op(mk(fpu_exc_pkg::OP_ADD, 4'hA, 1'b0, 10'h07F, 24'h800000, 1'b0), 1'b1);
    chk("dis_slot", 32'h1, r.dis_slot);
    op(mk(fpu_exc_pkg::OP_ADD, 4'h2, 1'b0, 10'h07F, 24'h800000, 1'b0), 1'b1);
    chk("dis_gen", 32'h1, r.dis_gen);
    rdr(1'b0);
    chk("status_off", 32'h00040000, rd);
  endtask
  // ==========================================
  // Main sequence: four-cycle reset, then scenarios
  initial begin
    repeat (4) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_reset_xfer();
    t_invalid_sticky();
    t_overflow();
    t_round_div();
    t_trap();
    t_unit_off();
    summarize();
  end
  // Watchdog well past the roughly 75 cycles the scenarios need
  initial begin
    #(5000 * 100);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
